/* File: testbench/rni_sup_model.sv */
// far side of the pins: reset supervisor and nmi source
// assumes the bench sets its requests at the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module rni_sup_model (
  // requests from the bench
  input wire logic rs_req,
  input wire logic nmi_req,
  // device side
  input wire logic dev_oe_n,
  output logic rs_wire,
  output logic nmi_n
);
  // open drain with pull-up, so whoever pulls low wins
  assign rs_wire = ~(rs_req | ~dev_oe_n);
  // held low as long as the bench asks, one cycle or more
  assign nmi_n = ~nmi_req;
endmodule // rni_sup_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the reset / nmi pin block
// assumes rni_pins and rni_sup_model; notes queue, negedge monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, wd = 0, mask = 0, ack = 0, rs_req = 0, nmi_req = 0;
  logic pin_o, oe_n, take_q = 0;
  wire logic rs_wire, nmi_n;
  rni_pkg::rni_core_ctl_t ctl;
  logic [15:0] pcv, stv;
  logic [7:0] expq[$];
  logic [7:0] obs;
  logic [31:0] rnd = 32'h5fe6f35a;
  int bad_count = 0, tests_run = 0, cyc = 0, run = 0;
  initial forever #10 clk = ~clk;
  rni_pins dut (.clk(clk), .rst_n(rst_n), .device_reset_pin_i(rs_wire),
    .device_reset_pin_o(pin_o), .device_reset_pin_oe_n(oe_n), .nmi_n_i(nmi_n),
    .wd_overflow(wd), .global_interrupt_mask_bit(mask), .nmi_ack(ack),
    .core_ctl(ctl), .pc_reset_value(pcv), .st_reset_value(stv));
  rni_sup_model sup (.rs_req(rs_req), .nmi_req(nmi_req), .dev_oe_n(oe_n),
    .rs_wire(rs_wire), .nmi_n(nmi_n));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // results: length of the driven pulse, else new nmi 4e, else fetch start 5f
  always @(negedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      print_verdict;
    end else begin
      obs = 8'h00;
      if (ctl.start_fetch === 1'b1) obs = 8'h5f;
      if (ctl.nmi_take === 1'b1 && take_q !== 1'b1) obs = 8'h4e;
      if (oe_n === 1'b0) run++;
      else if (run != 0) begin
        obs = run[7:0];
        run = 0;
      end
      take_q = ctl.nmi_take;
      // an unexpected result meets an empty queue and fails
      if (obs != 8'h00) chk(obs, expq.size() ? expq.pop_front() : 8'h00);
    end
  end
  initial begin
    expq.push_back(8'h5f);
    wait_n(3);
    rst_n = 1;
    wait_n(6);
    rs_req = 1;
    wait_n(5);
    chk({29'h0, ctl.halt, ctl.pc_clear, ctl.regs_clear}, 32'h7);
    chk({pcv, stv}, 32'h0);
    expq.push_back(8'h5f);
    rs_req = 0;
    wait_n(6);
    expq.push_back(8'h08);
    expq.push_back(8'h5f);
    wd = 1;
    wait_n(1);
    wd = 0;
    wait_n(2);
    chk({ctl.halt, pin_o}, 2'b10);
    wait_n(14);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      mask = rnd[0] | (i == 0);
      // a single low cycle is a glitch and is dropped
      if (i == 1) begin
        nmi_req = 1;
        wait_n(1);
        nmi_req = 0;
        wait_n(8);
      end else begin
        expq.push_back(8'h4e);
        nmi_req = 1;
        wait_n(2 + rnd[3:1]);
        nmi_req = 0;
        wait_n(8);
        ack = 1;
        wait_n(1);
        ack = 0;
        wait_n(2);
      end
    end
    // nmi and watchdog overflow while held in reset are both dropped
    rs_req = 1;
    wait_n(4);
    nmi_req = 1;
    wd = 1;
    wait_n(1);
    wd = 0;
    wait_n(3);
    nmi_req = 0;
    wait_n(2);
    expq.push_back(8'h5f);
    rs_req = 0;
    wait_n(8);
    // power-on reset again in mid-run
    rst_n = 0;
    wait_n(2);
    chk({29'h0, ctl.halt, ctl.start_fetch, oe_n}, 32'h5);
    expq.push_back(8'h5f);
    rst_n = 1;
    wait_n(6);
    chk(expq.size(), 0);
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire

/* File: verilog/rni_pins.sv */
// reset pin and nonmaskable interrupt pin logic of the cpu
// assumes one 50 mhz cpu clock; watchdog overflow arrives as a clk-domain pulse
`timescale 1ns/10ps
`default_nettype none
`include "rni_regs.svh"
module rni_pins (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reset pin, open drain
  input wire logic device_reset_pin_i,
  output logic device_reset_pin_o,
  output logic device_reset_pin_oe_n,
  // nmi pin
  input wire logic nmi_n_i,
  // watchdog and core side
  input wire logic wd_overflow,
  input wire logic global_interrupt_mask_bit,
  input wire logic nmi_ack,
  output var rni_pkg::rni_core_ctl_t core_ctl,
  output logic [15:0] pc_reset_value,
  output logic [15:0] st_reset_value
);

  typedef struct packed {
    rni_pkg::rni_state_t state;
    logic [3:0] cnt;
    logic nmi_prev;
    logic nmi_edge;
    logic nmi_pend;
    logic pin_o;
    logic pin_oe_n;
    rni_pkg::rni_core_ctl_t ctl;
    // constants held in flops so every output leaves a register
    logic [15:0] pc_rst;
    logic [15:0] st_rst;
  } rni_st_t;

  rni_st_t st_q;
  rni_st_t st_d;
  logic rs_lvl;
  logic nmi_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  rni_sync #(.RST_VAL(1'b0)) u_rs_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_i(device_reset_pin_i),
    .level_o(rs_lvl)
  );

  rni_sync #(.RST_VAL(1'b1)) u_nmi_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_i(nmi_n_i),
    .level_o(nmi_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.ctl.start_fetch = 1'b0;
    st_d.nmi_prev = nmi_lvl;
    st_d.nmi_edge = 1'b0;
    unique case (st_q.state)
      rni_pkg::RNI_RUN: begin
        if (wd_overflow) begin
          st_d.state = rni_pkg::RNI_WD_DRIVE;
          st_d.cnt = `RNI_WD_PULSE_CYCLES - 4'h1;
          st_d.pin_o = 1'b0;
          st_d.pin_oe_n = 1'b0;
        end else if (!rs_lvl) begin
          st_d.state = rni_pkg::RNI_HALT;
        end
      end
      rni_pkg::RNI_WD_DRIVE: begin
        // own drive shows on the pin; release after eight cycles
        if (st_q.cnt == 4'h0) begin
          st_d.pin_oe_n = 1'b1;
          st_d.state = rni_pkg::RNI_HALT;
        end else begin
          st_d.cnt = st_q.cnt - 4'h1;
        end
      end
      rni_pkg::RNI_HALT: begin
        // wait for our drive to clear the synchroniser before release
        if (rs_lvl && st_q.pin_oe_n) begin
          st_d.state = rni_pkg::RNI_RUN;
          st_d.ctl.start_fetch = 1'b1;
        end
      end
    endcase
    st_d.ctl.halt = (st_d.state != rni_pkg::RNI_RUN);
    st_d.ctl.pc_clear = st_d.ctl.halt;
    st_d.ctl.regs_clear = st_d.ctl.halt;
    // falling edge then low level on the next cycle
    if (st_q.nmi_prev && !nmi_lvl) begin
      st_d.nmi_edge = 1'b1;
    end
    if (st_q.nmi_edge && !nmi_lvl && !st_q.ctl.halt) begin
      st_d.nmi_pend = 1'b1;
    end else if (nmi_ack) begin
      st_d.nmi_pend = 1'b0;
    end
    if (st_d.ctl.halt) begin
      st_d.nmi_pend = 1'b0;
    end
    // mask bit deliberately not consulted
    st_d.ctl.nmi_take = st_d.nmi_pend;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.state <= rni_pkg::RNI_HALT;
      st_q.cnt <= 4'h0;
      st_q.nmi_prev <= 1'b1;
      st_q.nmi_edge <= 1'b0;
      st_q.nmi_pend <= 1'b0;
      st_q.pin_o <= 1'b0;
      st_q.pin_oe_n <= 1'b1;
      st_q.ctl <= 5'h1c;
      st_q.pc_rst <= `RNI_PC_RESET;
      st_q.st_rst <= `RNI_ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign device_reset_pin_o = st_q.pin_o;
  assign device_reset_pin_oe_n = st_q.pin_oe_n;
  assign core_ctl = st_q.ctl;
  assign pc_reset_value = st_q.pc_rst;
  assign st_reset_value = st_q.st_rst;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence wd_start_s;
    st_q.state == rni_pkg::RNI_RUN && wd_overflow;
  endsequence

  sequence drive_low8_s;
    !device_reset_pin_oe_n [*8];
  endsequence

  sequence nmi_fall_low_s;
    $fell(nmi_lvl) && !core_ctl.halt ##1 !nmi_lvl && !core_ctl.halt && !st_d.ctl.halt;
  endsequence

  AST_WD_PULSE8: assert property (@(posedge clk) disable iff (!rst_n)
    wd_start_s |=> drive_low8_s ##1 device_reset_pin_oe_n)
    else $error("watchdog reset pulse not eight cycles");

  AST_WD_HALTS: assert property (@(posedge clk) disable iff (!rst_n)
    wd_start_s |=> core_ctl.halt && !device_reset_pin_o)
    else $error("watchdog overflow did not start reset");

  AST_PIN_HALT: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == rni_pkg::RNI_RUN && !rs_lvl && !wd_overflow) |=>
      core_ctl.halt && core_ctl.pc_clear)
    else $error("reset pin low did not halt core");

  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(core_ctl.halt) |-> core_ctl.start_fetch)
    else $error("release without fetch start");

  AST_REGS_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    core_ctl.halt |-> core_ctl.regs_clear && core_ctl.pc_clear &&
      pc_reset_value == 16'h0000 && st_reset_value == 16'h0000)
    else $error("registers not cleared during reset");

  AST_NMI_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_fall_low_s |=> core_ctl.nmi_take)
    else $error("nmi not taken");

  AST_NMI_GLITCH: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_q.nmi_pend && !st_q.nmi_edge && !($fell(nmi_lvl))) |=> !st_q.nmi_pend)
    else $error("nmi taken without edge and low level");

  AST_SYNC2: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(st_q.nmi_edge) |-> $past(nmi_lvl, 2) == 1'b0 || $past(nmi_lvl, 3) == 1'b1)
    else $error("nmi edge timing wrong");

  AST_NMI_NO_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.nmi_edge && !nmi_lvl && !core_ctl.halt && !st_d.ctl.halt &&
      global_interrupt_mask_bit) |=> core_ctl.nmi_take)
    else $error("nmi blocked by mask bit");

  AST_NMI_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (core_ctl.nmi_take && !nmi_ack && !st_d.ctl.halt) |=> core_ctl.nmi_take)
    else $error("pending nmi lost without ack");

  AST_NMI_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (core_ctl.nmi_take && nmi_ack && !st_q.nmi_edge) |=> !core_ctl.nmi_take)
    else $error("nmi ack did not clear pending");

  AST_NMI_HALT_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    core_ctl.halt |-> !core_ctl.nmi_take)
    else $error("nmi pending while halted");

  AST_WD_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state != rni_pkg::RNI_RUN && wd_overflow && device_reset_pin_oe_n) |=>
      device_reset_pin_oe_n)
    else $error("overflow while halted drove the pin");

  AST_OE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    !device_reset_pin_oe_n |-> !device_reset_pin_o && core_ctl.halt)
    else $error("pin driven without halt or not low");

  AST_WD_HOLD_HALT: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(device_reset_pin_oe_n) && !rs_lvl) |-> core_ctl.halt)
    else $error("released before pin reads high");

  AST_FETCH_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    core_ctl.start_fetch |=> !core_ctl.start_fetch)
    else $error("fetch start longer than one cycle");

  AST_PC_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    core_ctl.start_fetch |-> !core_ctl.halt && pc_reset_value == 16'h0000)
    else $error("fetch start not from address zero");

  AST_HALT_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == rni_pkg::RNI_HALT && !rs_lvl) |=> core_ctl.halt)
    else $error("left halt while reset pin low");

endmodule // rni_pins
`default_nettype wire

/* File: verilog/rni_pkg.sv */
// types for the reset / nmi pin block
// assumes rni_regs.svh holds the numeric constants
package rni_pkg;

  typedef enum logic [1:0] {
    RNI_RUN,
    RNI_HALT,
    RNI_WD_DRIVE
  } rni_state_t;

  // what the core sees from this block
  typedef struct packed {
    logic halt;
    logic pc_clear;
    logic regs_clear;
    logic start_fetch;
    logic nmi_take;
  } rni_core_ctl_t;

endpackage

/* File: verilog/rni_regs.svh */
// timing counts and reset values for the reset / nmi pin block
// assumes a single 50 mhz cpu clock
`ifndef RNI_REGS_SVH
`define RNI_REGS_SVH
`define RNI_CLK_PERIOD_NS 20
`define RNI_WD_PULSE_CYCLES 4'h8
`define RNI_PC_RESET 16'h0000
`define RNI_ST_RESET 16'h0000
`endif

/* File: verilog/rni_sync.sv */
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module rni_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and synced level
  input wire logic pin_i,
  output logic level_o
);

  typedef struct packed {
    logic s1;
    logic s2;
  } rni_sync_st_t;

  rni_sync_st_t st_q;
  rni_sync_st_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.s2;

endmodule // rni_sync
`default_nettype wire
